/* ebi_async_bus.v */
// external non-multiplexed async bus master port
// assumes internal master holds reqValid and fields until reqDone
// assumes the stall pin is asynchronous to clk_sys
// assumes busClkDiv and waitStates only change between accesses
`include "ebi_regs.vh"
module ebi_async_bus (
   input wire clk_sys,
   input wire rst_b,
   input wire [2:0] busClkDiv,
   input wire [1:0] waitStates,
   input wire reqValid,
   input wire reqWrite,
   input wire [`EBI_AW-1:0] reqAddr,
   input wire [`EBI_DW-1:0] reqWdata,
   output wire reqBusy,
   output reg reqDone,
   output reg [`EBI_DW-1:0] reqRdata,
   output wire busClkOut,
   output reg [`EBI_AW-1:0] busAddr,
   output reg [`EBI_DW-1:0] busDataOut,
   output reg busDataOe,
   input wire [`EBI_DW-1:0] busDataIn,
   output reg [`EBI_NCS-1:0] chipSel_b,
   output reg rdStrobe_b,
   output reg wrStrobe_b,
   input wire external_stall_in_b
);
   localparam ST_IDLE = 2'h0;
   localparam ST_MIN = 2'h1;
   localparam ST_WAIT = 2'h2;
   localparam ST_STALL = 2'h3;
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [1:0] cnt_q;
   reg [1:0] cnt_d;
   // clocks since the strobe fell, saturating
   reg [2:0] lat_q;
   reg [2:0] lat_d;
   reg stallS1_q, stallS2_q, stallS3_q;
   reg stall_q;
   // next values of the registered outputs
   reg reqDone_d;
   reg [`EBI_DW-1:0] reqRdata_d;
   reg [`EBI_AW-1:0] busAddr_d;
   reg [`EBI_DW-1:0] busDataOut_d;
   reg busDataOe_d;
   reg [`EBI_NCS-1:0] chipSel_d;
   reg rdStrobe_d;
   reg wrStrobe_d;
   wire busTick;
   wire takeReq;
   wire finish;
   ebi_clk_gen uClk (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .divSel(busClkDiv),
      .busClk(busClkOut),
      .busTick(busTick)
   );
   // decode one chip select from the top address bits
   function [`EBI_NCS-1:0] csDecode;
      input [`EBI_AW-1:0] a;
      begin
         case (a[`EBI_CS_HI:`EBI_CS_LO])
            `EBI_SEL_0: csDecode = `EBI_CS_0;
            `EBI_SEL_1: csDecode = `EBI_CS_1;
            `EBI_SEL_2: csDecode = `EBI_CS_2;
            // top quarter selects nothing; access still runs
            default: csDecode = `EBI_CS_NONE;
         endcase
      end
   endfunction
   // pin sync: a change counts once stages two and three agree
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         stallS1_q <= 1'b1;
         stallS2_q <= 1'b1;
         stallS3_q <= 1'b1;
         stall_q <= 1'b0;
      end else begin
         stallS1_q <= external_stall_in_b;
         stallS2_q <= stallS1_q;
         stallS3_q <= stallS2_q;
         if (stallS2_q == stallS3_q)
            stall_q <= !stallS3_q;
      end
   end
   assign reqBusy = (state_q != ST_IDLE);
   // start only on a bus clock edge, never in the done cycle
   assign takeReq = reqValid && !reqDone && busTick;
   // the stall pin needs four clocks to reach stall_q; ending sooner
   // would miss a peripheral that stalls right at the strobe edge,
   // at the cost of a six-clock floor on undivided accesses
   assign finish = busTick && !stall_q &&
      (lat_q >= `EBI_SYNC_LAT);
   always @* begin
      state_d = state_q;
      cnt_d = cnt_q;
      lat_d = lat_q;
      reqDone_d = 1'b0;
      reqRdata_d = reqRdata;
      busAddr_d = busAddr;
      busDataOut_d = busDataOut;
      busDataOe_d = busDataOe;
      chipSel_d = chipSel_b;
      rdStrobe_d = rdStrobe_b;
      wrStrobe_d = wrStrobe_b;
      if (lat_q != `EBI_SYNC_LAT) begin
         lat_d = lat_q + 3'h1;
      end
      case (state_q)
         ST_IDLE: begin
            if (takeReq) begin
               busAddr_d = reqAddr;
               busDataOut_d = reqWdata;
               busDataOe_d = reqWrite;
               chipSel_d = ~csDecode(reqAddr);
               rdStrobe_d = reqWrite;
               wrStrobe_d = !reqWrite;
               cnt_d = `EBI_MIN_CYC - 2'h1;
               lat_d = `EBI_LAT_ZERO;
               state_d = ST_MIN;
            end
         end
         ST_MIN: begin
            // two bus clocks minimum
            if (busTick) begin
               if (cnt_q != `EBI_DIV_ZERO) begin
                  cnt_d = cnt_q - 2'h1;
               end else if (waitStates != `EBI_DIV_ZERO) begin
                  cnt_d = waitStates - 2'h1;
                  state_d = ST_WAIT;
               end else begin
                  state_d = ST_STALL;
               end
            end
         end
         ST_WAIT: begin
            if (busTick) begin
               if (cnt_q != `EBI_DIV_ZERO) begin
                  cnt_d = cnt_q - 2'h1;
               end else begin
                  state_d = ST_STALL;
               end
            end
         end
         ST_STALL: begin
            // stall held by the peripheral blocks here
            if (finish) begin
               reqRdata_d = busDataIn;
               reqDone_d = 1'b1;
               chipSel_d = {`EBI_NCS{1'b1}};
               rdStrobe_d = 1'b1;
               wrStrobe_d = 1'b1;
               busDataOe_d = 1'b0;
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end
   // every pin output comes straight from a flop, so no glitches
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         state_q <= ST_IDLE;
         cnt_q <= `EBI_DIV_ZERO;
         lat_q <= `EBI_LAT_ZERO;
         reqDone <= 1'b0;
         reqRdata <= {`EBI_DW{1'b0}};
         busAddr <= {`EBI_AW{1'b0}};
         busDataOut <= {`EBI_DW{1'b0}};
         busDataOe <= 1'b0;
         chipSel_b <= {`EBI_NCS{1'b1}};
         rdStrobe_b <= 1'b1;
         wrStrobe_b <= 1'b1;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         lat_q <= lat_d;
         reqDone <= reqDone_d;
         reqRdata <= reqRdata_d;
         busAddr <= busAddr_d;
         busDataOut <= busDataOut_d;
         busDataOe <= busDataOe_d;
         chipSel_b <= chipSel_d;
         rdStrobe_b <= rdStrobe_d;
         wrStrobe_b <= wrStrobe_d;
      end
   end
endmodule // ebi_async_bus

/* ebi_async_bus_assertions.sv */
// pin checks for the async bus port
// bound to ebi_async_bus; one clock
module ebi_chk (
   input wire clk_sys,
   input wire rst_b,
   input wire [2:0] busClkDiv,
   input wire reqBusy,
   input wire reqDone,
   input wire [22:0] busAddr,
   input wire busDataOe,
   input wire [2:0] chipSel_b,
   input wire rdStrobe_b,
   input wire wrStrobe_b,
   input wire external_stall_in_b
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   a_one_cs:
   assert property ($onehot0(~chipSel_b)) else $error("two cs");
   a_strobe_excl:
   assert property (rdStrobe_b | wrStrobe_b) else $error("rd and wr");
   a_addr_hold:
   assert property (reqBusy && $past(reqBusy) |-> $stable(busAddr))
      else $error("addr moved");
   a_min_len:
   assert property ($rose(reqBusy) |-> !reqDone[*3]) else $error("short");
   a_wr_drive:
   assert property (!wrStrobe_b |-> busDataOe) else $error("no drive");
   a_rd_float:
   assert property (!rdStrobe_b |-> !busDataOe) else $error("drive rd");
   a_stall_hold:
   assert property (reqDone |-> $past(external_stall_in_b, 2))
      else $error("done in stall");
   a_stop_idle:
   assert property (busClkDiv[2] && !reqBusy |=> !reqBusy)
      else $error("ran stopped");
endmodule // ebi_chk
bind ebi_async_bus ebi_chk chk (.*);

/* ebi_clk_gen.v */
// bus clock divider: one-cycle tick on each bus clock rising edge
// assumes divSel is static or changes between accesses
`include "ebi_regs.vh"
module ebi_clk_gen (
   input wire clk_sys,
   input wire rst_b,
   input wire [2:0] divSel,
   output reg busClk,
   output wire busTick
);
   reg [1:0] cnt_q;
   reg [1:0] last;
   always @* begin
      case (divSel)
         `EBI_DIV_2: last = 2'h1;
         `EBI_DIV_3: last = 2'h2;
         `EBI_DIV_4: last = 2'h3;
         default: last = 2'h0;
      endcase
   end
   wire stopped = (divSel == `EBI_DIV_STOP);
   // div 1 cannot be made from flops; busClk then mirrors phase only
   assign busTick = !stopped && (cnt_q == `EBI_DIV_ZERO);
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         cnt_q <= `EBI_DIV_ZERO;
         busClk <= 1'b0;
      end else if (stopped) begin
         cnt_q <= `EBI_DIV_ZERO;
         busClk <= 1'b0;
      end else begin
         // free running, not tied to accesses
         cnt_q <= (cnt_q >= last) ? `EBI_DIV_ZERO : cnt_q + 2'h1;
         busClk <= (divSel == `EBI_DIV_1) ? ~busClk :
            ({1'b0, cnt_q} < (({1'b0, last} + 3'h1) >> 1));
      end
   end
endmodule // ebi_clk_gen

/* ebi_mem.sv */
// async memory model, 16 words, on chip select 0
// stalls for stallLen clocks from each strobe fall
module ebi_mem (
   input wire clk_sys,
   input wire [22:0] busAddr,
   input wire [15:0] busDataOut,
   input wire [2:0] chipSel_b,
   input wire rdStrobe_b,
   input wire wrStrobe_b,
   input wire [7:0] stallLen,
   output logic [15:0] busDataIn,
   output logic external_stall_in_b
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] m [16];
   logic [7:0] n;
   always @(posedge clk_sys) begin
      if (!wrStrobe_b && !chipSel_b[0]) m[busAddr[3:0]] <= busDataOut;
      n <= (rdStrobe_b && wrStrobe_b) ? 8'h00 : n + 8'h01;
   end
   assign external_stall_in_b = (rdStrobe_b && wrStrobe_b) ||
      n >= stallLen;
   // off-read data inverted so stale samples show
   assign busDataIn = (!rdStrobe_b && !chipSel_b[0]) ? m[busAddr[3:0]]
                                                     : ~m[busAddr[3:0]];
endmodule // ebi_mem

/* ebi_regs.vh */
// constants for the external async bus interface
// assumes one 250 MHz clock and synchronous active-low reset
// What this block does
// - separate 23-bit address, 16-bit data lines
// - three chip selects, read and write strobes
// - bus clock output runs free unless halted, then held low
// - bus clock divide 1,2,3,4 or halted; at divide 1 the bus clock output toggles each clock, half rate
// - every access lasts at least two bus clocks
// - direction shown by separate read/write strobes
// - programmed zero to three extra wait states
// - stall input extends access without limit
`ifndef EBI_REGS_VH
`define EBI_REGS_VH
`define EBI_AW 23
`define EBI_DW 16
`define EBI_NCS 3
// clock divide select codes
`define EBI_DIV_1 3'h0
`define EBI_DIV_2 3'h1
`define EBI_DIV_3 3'h2
`define EBI_DIV_4 3'h3
`define EBI_DIV_STOP 3'h4
// chip select decode on the top two address bits
`define EBI_CS_HI 22
`define EBI_CS_LO 21
`define EBI_MIN_CYC 2'h2
`define EBI_DIV_ZERO 2'h0
// chip select codes, active high before inversion
`define EBI_SEL_0 2'h0
`define EBI_SEL_1 2'h1
`define EBI_SEL_2 2'h2
`define EBI_CS_0 3'h1
`define EBI_CS_1 3'h2
`define EBI_CS_2 3'h4
`define EBI_CS_NONE 3'h0
// clocks from strobe edge until the stall sync has seen the pin
`define EBI_SYNC_LAT 3'h4
`define EBI_LAT_ZERO 3'h0
`endif

/* external_async_bus_interface_bench.sv */
// bench for the async bus port with a memory model
// inputs change on falling edges, 4 ns clock
module external_async_bus_interface_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 0, rst_b = 0, reqValid = 0, reqWrite = 0;
   logic [2:0] busClkDiv = 0, chipSel_b;
   logic [1:0] waitStates = 0;
   logic [22:0] reqAddr = 0, busAddr;
   logic [15:0] reqWdata = 0, reqRdata, busDataOut, busDataIn;
   logic [7:0] stallLen = 0;
   logic reqBusy, reqDone, busClkOut, busDataOe, rdStrobe_b, wrStrobe_b;
   logic external_stall_in_b;
   int fail_count = 0, n_checks = 0, c;
   always #2 clk_sys = ~clk_sys;
   ebi_async_bus uut (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .busClkDiv(busClkDiv),
      .waitStates(waitStates),
      .reqValid(reqValid),
      .reqWrite(reqWrite),
      .reqAddr(reqAddr),
      .reqWdata(reqWdata),
      .reqBusy(reqBusy),
      .reqDone(reqDone),
      .reqRdata(reqRdata),
      .busClkOut(busClkOut),
      .busAddr(busAddr),
      .busDataOut(busDataOut),
      .busDataOe(busDataOe),
      .busDataIn(busDataIn),
      .chipSel_b(chipSel_b),
      .rdStrobe_b(rdStrobe_b),
      .wrStrobe_b(wrStrobe_b),
      .external_stall_in_b(external_stall_in_b)
   );
   ebi_mem mem (.*);
   task chk(input [15:0] g, input [15:0] e);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %0t %h %h", $time, g, e);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task xfer(input w, input [22:0] a, input [15:0] d);
      @(negedge clk_sys);
      {reqValid, reqWrite, reqAddr, reqWdata} = {1'b1, w, a, d};
      for (c = 0; reqDone !== 1'b1; c++) begin
         @(negedge clk_sys);
         if (c > 900) begin
            fail_count++;
            tally_and_finish;
         end
      end
      reqValid = 0;
   endtask
   task t_waits;
      for (int d = 0; d < 4; d++)
         for (int w = 0; w < 4; w++) begin
            busClkDiv = d;
            waitStates = w;
            xfer(1, d * 4 + w, 16'h5a00 + d * 4 + w);
            xfer(0, d * 4 + w, 16'h0000);
            chk(reqRdata, 16'h5a00 + d * 4 + w);
            // undivided: stall sync sets a floor of six clocks
            if (d == 0) chk(c, (4 + w > 6) ? 4 + w : 6);
            else chk(c >= (2 + w) * (d + 1), 1);
         end
   endtask
   task t_stall;
      busClkDiv = 0;
      waitStates = 0;
      stallLen = 40;
      xfer(0, 5, 16'h0000);
      chk(reqRdata, 16'h5a05);
      chk(c > 40, 1);
      stallLen = 0;
   endtask
   task t_stop;
      busClkDiv = 4;
      reqValid = 1;
      repeat (30) @(negedge clk_sys);
      chk(reqBusy, 0);
      // drop the request first so no stale access starts on restart
      reqValid = 0;
      busClkDiv = 0;
      // decode 3 selects no part, so word 3 must survive
      xfer(1, 23'h600003, 16'h0bad);
      xfer(0, 3, 16'h0000);
      chk(reqRdata, 16'h5a03);
   endtask
   task t_clk;
      int r;
      logic p;
      for (int d = 0; d < 5; d++) begin
         busClkDiv = d;
         repeat (4) @(negedge clk_sys);
         r = 0;
         p = busClkOut;
         repeat (24) begin
            @(negedge clk_sys);
            if (busClkOut && !p) r++;
            p = busClkOut;
         end
         // undivided output toggles every clock: half-rate waveform
         chk(r, (d == 4) ? 0 : (d == 0) ? 12 : 24 / (d + 1));
      end
      busClkDiv = 0;
   endtask
   initial begin
      repeat (10) @(negedge clk_sys);
      rst_b = 1;
      t_clk;
      t_waits;
      t_stall;
      t_stop;
      tally_and_finish;
   end
endmodule // external_async_bus_interface_bench
